// file: logic/datapath_config_register.sv
// Datapath control word with its serial configuration port and fault pin drive
//
// How it works
// RQ1 - Bit 15 enables AB IQ offset correction
// RQ2 - Bit 14 enables CD IQ offset correction
// RQ3 - Bit 13 enables AB gain/phase correction
// RQ4 - Bit 12 enables CD gain/phase correction
// RQ5 - Bits 11:8 select interpolation 1x..16x
// RQ6 - Bit 7 enables input FIFO, resets one
// RQ7 - Bit 4 drives fault pin, else hi-Z
// RQ8 - Bit 3 sets fault polarity, one high
// RQ9 - Bit 2 allows divider and pointer sync
// RQ10 - Sync phase-aligns all divided clocks
// RQ11 - Bit 1 enables AB inverse sinc filter
// RQ12 - Bit 0 enables CD inverse sinc filter
// RQ13 - Software keeps bits 6 and 5 zero
// RQ14 - Word resets to 0x049C
// RQ15 - Fields read back; effect next cycle
//
// Serial port: SEN_N low frames a 24-bit transfer, MSB first on SCLK rising:
// bit 23 read(1)/write(0), bits 22:16 address, bits 15:0 data. Read data
// leaves on SDO_OUT, changing after each accepted SCLK falling edge.
`include "dpcfg_map.svh"
module datapath_config_register
  import dpcfg_pkg::*;
(
  // Clock and reset
  input wire logic REF_CLK_IN,
  input wire logic RESETN_IN,
  // Serial configuration port pins
  input wire logic SCLK_IN,
  input wire logic SEN_N_IN,
  input wire logic SDI_IN,
  output logic SDO_OUT,
  output logic SDO_OE_OUT,
  // Sync source pulse from the selected alignment source
  input wire logic ALIGN_EVENT_IN,
  // Fault request from the alarm logic, active high
  input wire logic FAULT_REQ_IN,
  // Fault pin, two signals
  output logic FAULT_OUT,
  output logic FAULT_OE_OUT,
  // Settings to the data path
  output dp_cfg_s CFG_OUT,
  output rate_e RATE_OUT,
  // Phase-aligned divided clock enables, one per rate
  output logic [4:0] DIV_EN_OUT
);
  logic sclk_s;  // Synchronised pin levels
  logic sen_n_s;
  logic sdi_s;
  logic align_s;

  // Pin synchronisers, one per serial port input pin and one for the sync source
  pin_sync u_sync_sclk (.clk(REF_CLK_IN), .rst_n(RESETN_IN), .din(SCLK_IN), .dout(sclk_s));
  // Frame enable idles high, so its synchroniser must come out of reset high too
  pin_sync #(.RST_LEVEL(1'b1)) u_sync_sen (.clk(REF_CLK_IN), .rst_n(RESETN_IN),
    .din(SEN_N_IN), .dout(sen_n_s));
  pin_sync u_sync_sdi (.clk(REF_CLK_IN), .rst_n(RESETN_IN), .din(SDI_IN), .dout(sdi_s));
  pin_sync u_sync_aln (.clk(REF_CLK_IN), .rst_n(RESETN_IN), .din(ALIGN_EVENT_IN),
    .dout(align_s));

  logic [15:0] word_q;  // The control word
  logic [15:0] word_d;
  sp_state_e state_q;  // Serial port state
  sp_state_e state_d;
  logic [4:0] cnt_q;  // Bits received in this frame
  logic [4:0] cnt_d;
  logic [23:0] shift_q;  // Incoming frame
  logic [23:0] shift_d;
  logic [15:0] rd_q;  // Outgoing read data
  logic [15:0] rd_d;
  logic rd_act_q;  // Frame is a read of this word
  logic rd_act_d;
  logic sdo_q;
  logic sdo_d;
  logic sclk_q;  // Previous synchronised SCLK, for edges
  logic align_q;  // Previous sync level, for edges
  logic [3:0] div_q;  // Shared divider counter
  logic [3:0] div_d;
  logic sclk_rise;
  logic sclk_fall;
  logic align_edge;

  assign sclk_rise = sclk_s & ~sclk_q;
  assign sclk_fall = ~sclk_s & sclk_q;
  assign align_edge = align_s & ~align_q;

  // Serial port and word update
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    shift_d = shift_q;
    word_d = word_q;
    rd_d = rd_q;
    rd_act_d = rd_act_q;
    sdo_d = sdo_q;
    case (state_q)
      SP_IDLE:
      begin
        // Frame opens on SEN_N low
        cnt_d = 5'h00;
        rd_act_d = 1'b0;
        sdo_d = 1'b0;
        if (!sen_n_s)
        begin
          state_d = SP_SHIFT;
        end
      end
      SP_SHIFT:
      begin
        if (sen_n_s)
        begin
          // Short frame is dropped; nothing written
          state_d = SP_IDLE;
        end
        else
        begin
          if (sclk_rise)
          begin
            shift_d = {shift_q[22:0], sdi_s};
            cnt_d = cnt_q + 5'h01;
            // Command and address complete: arm readback
            if (cnt_q == 5'h07)
            begin
              rd_act_d = shift_q[6] && ({shift_q[5:0], sdi_s} == `DPCW_ADDR);
              rd_d = word_q;  // RQ15
            end
            if (cnt_q == 5'h17)
            begin
              state_d = SP_DONE;
              // Write takes effect from the next cycle
              if (!shift_q[22] && (shift_q[21:15] == `DPCW_ADDR))
              begin
                word_d = {shift_q[14:0], sdi_s};  // RQ15
              end
            end
          end
          if (sclk_fall && rd_act_q)
          begin
            sdo_d = rd_q[15];
            rd_d = {rd_q[14:0], 1'b0};
          end
        end
      end
      SP_DONE:
      begin
        // Wait for the frame to close
        if (sen_n_s)
        begin
          state_d = SP_IDLE;
        end
      end
      default:
      begin
        state_d = SP_IDLE;
      end
    endcase
  end

  // Serial port registers; the word resets to its documented value
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      word_q <= `DPCW_RESET;  // RQ14 RQ6
      state_q <= SP_IDLE;
      cnt_q <= 5'h00;
      shift_q <= 24'h000000;
      rd_q <= 16'h0000;
      rd_act_q <= 1'b0;
      sdo_q <= 1'b0;
      sclk_q <= 1'b0;
    end
    else
    begin
      word_q <= word_d;
      state_q <= state_d;
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      rd_q <= rd_d;
      rd_act_q <= rd_act_d;
      sdo_q <= sdo_d;
      sclk_q <= sclk_s;
    end
  end

  // Readback drives SDO only during a read frame
  assign SDO_OUT = sdo_q;
  assign SDO_OE_OUT = rd_act_q & ~sen_n_s;

  // Divider: restarting the single counter aligns every divided clock at once
  always_comb
  begin
    div_d = div_q + 4'h1;
    if (align_edge && word_q[`DPCW_BIT_ALIGN])
    begin
      div_d = 4'h0;  // RQ9 RQ10
    end
  end

  // Divider registers
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      div_q <= 4'h0;
      align_q <= 1'b0;
    end
    else
    begin
      div_q <= div_d;
      align_q <= align_s;
    end
  end

  // Enables 1 to 4 derive from the same counter and enable 0 is always set, so they stay phase aligned
  always_comb
  begin
    DIV_EN_OUT[0] = 1'b1;
    DIV_EN_OUT[1] = (div_q[0] == 1'b0);  // RQ10
    DIV_EN_OUT[2] = (div_q[1:0] == 2'h0);
    DIV_EN_OUT[3] = (div_q[2:0] == 3'h0);
    DIV_EN_OUT[4] = (div_q == 4'h0);
  end

  // Settings to the data path come straight from the word
  always_comb
  begin
    CFG_OUT.dc_fix_ab = word_q[`DPCW_BIT_DC_AB];  // RQ1
    CFG_OUT.dc_fix_cd = word_q[`DPCW_BIT_DC_CD];  // RQ2
    CFG_OUT.gain_phase_ab = word_q[`DPCW_BIT_GP_AB];  // RQ3
    CFG_OUT.gain_phase_cd = word_q[`DPCW_BIT_GP_CD];  // RQ4
    CFG_OUT.interp = word_q[`DPCW_INTERP_HI:`DPCW_INTERP_LO];  // RQ5
    CFG_OUT.fifo_on = word_q[`DPCW_BIT_FIFO];  // RQ6
    CFG_OUT.fault_drive = word_q[`DPCW_BIT_FAULT_OE];  // RQ7
    CFG_OUT.fault_high = word_q[`DPCW_BIT_FAULT_POL];  // RQ8
    CFG_OUT.align_on = word_q[`DPCW_BIT_ALIGN];  // RQ9
    CFG_OUT.sinc_ab = word_q[`DPCW_BIT_SINC_AB];  // RQ11
    CFG_OUT.sinc_cd = word_q[`DPCW_BIT_SINC_CD];  // RQ12
  end

  // Rate decode; undefined codes fall back to 1x, which is the safe case
  always_comb
  begin
    case (word_q[`DPCW_INTERP_HI:`DPCW_INTERP_LO])
      `INTERP_1X: RATE_OUT = RATE_1X;  // RQ5
      `INTERP_2X: RATE_OUT = RATE_2X;
      `INTERP_4X: RATE_OUT = RATE_4X;
      `INTERP_8X: RATE_OUT = RATE_8X;
      `INTERP_16X: RATE_OUT = RATE_16X;
      default: RATE_OUT = RATE_1X;
    endcase
  end

  // Fault pin: polarity then tri-state control
  assign FAULT_OUT = word_q[`DPCW_BIT_FAULT_POL] ? FAULT_REQ_IN : ~FAULT_REQ_IN;  // RQ8
  assign FAULT_OE_OUT = word_q[`DPCW_BIT_FAULT_OE];  // RQ7

  // Reserved bits 6:5 are stored as written; software keeps them zero (RQ13 binds it)

  AST_RESET_VALUE: assert property (@(posedge REF_CLK_IN)  // RQ14
    $rose(RESETN_IN) |-> word_q == 16'h049c)
    else $error("control word not at reset value");

  // A frame never opens in the first two cycles after reset is released
  AST_IDLE_AFTER_RESET: assert property (@(posedge REF_CLK_IN)  // RQ15
    $rose(RESETN_IN) |-> state_q == SP_IDLE ##1 state_q == SP_IDLE)
    else $error("frame opened straight after reset");

  AST_OE_FOLLOWS: assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)  // RQ7
    FAULT_OE_OUT == word_q[4])
    else $error("fault enable mismatch");

  AST_POLARITY: assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)  // RQ8
    FAULT_OUT == (word_q[3] ~^ FAULT_REQ_IN))
    else $error("fault polarity wrong");

  AST_RATE8: assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)  // RQ5
    word_q[11:8] == 4'h4 |-> RATE_OUT == RATE_8X)
    else $error("8x decode wrong");

  // Divider restart: zero on the cycle after the event, counting on from there
  sequence s_div_restart;
    div_q == 4'h0 ##1 div_q == 4'h1;
  endsequence

  AST_ALIGN: assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)  // RQ9
    align_edge && word_q[2] |=> s_div_restart)
    else $error("divider not realigned");

  AST_NO_ALIGN: assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)  // RQ9
    !word_q[2] |=> div_q == $past(div_q) + 4'h1)
    else $error("divider moved while sync disabled");

  AST_PHASE: assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)  // RQ10
    DIV_EN_OUT[4] |-> &DIV_EN_OUT)
    else $error("divided clocks out of phase");

  sequence s_write_done;
    state_q == SP_SHIFT && sclk_rise && cnt_q == 5'h17 && !shift_q[22]
      && shift_q[21:15] == 7'h00;
  endsequence

  AST_WRITE: assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)  // RQ15
    s_write_done |=> word_q == {$past(shift_q[14:0]), $past(sdi_s)}
      ##1 CFG_OUT.interp == word_q[11:8])
    else $error("write not applied");

  AST_HOLD: assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)  // RQ15
    state_q != SP_SHIFT |=> word_q == $past(word_q))
    else $error("word changed outside a frame");

  AST_CFG_BITS: assert property (  // RQ1 RQ2 RQ3 RQ4 RQ6 RQ11 RQ12
    @(posedge REF_CLK_IN) disable iff (!RESETN_IN)
    {CFG_OUT.dc_fix_ab, CFG_OUT.dc_fix_cd, CFG_OUT.gain_phase_ab, CFG_OUT.gain_phase_cd,
     CFG_OUT.fifo_on, CFG_OUT.sinc_ab, CFG_OUT.sinc_cd}
      == {word_q[15:12], word_q[7], word_q[1:0]})
    else $error("enable bits mismatch");
endmodule

// file: include/dpcfg_map.svh
// Offsets, field positions, reset value and timing counts of the datapath control word
`ifndef DPCFG_MAP_SVH
`define DPCFG_MAP_SVH
`define DPCW_ADDR 7'h00
`define DPCW_RESET 16'h049c
`define DPCW_BIT_DC_AB 15
`define DPCW_BIT_DC_CD 14
`define DPCW_BIT_GP_AB 13
`define DPCW_BIT_GP_CD 12
`define DPCW_INTERP_HI 11
`define DPCW_INTERP_LO 8
`define DPCW_BIT_FIFO 7
`define DPCW_BIT_RSV6 6
`define DPCW_BIT_RSV5 5
`define DPCW_BIT_FAULT_OE 4
`define DPCW_BIT_FAULT_POL 3
`define DPCW_BIT_ALIGN 2
`define DPCW_BIT_SINC_AB 1
`define DPCW_BIT_SINC_CD 0
`define INTERP_1X 4'h0
`define INTERP_2X 4'h1
`define INTERP_4X 4'h2
`define INTERP_8X 4'h4
`define INTERP_16X 4'h8
`define DIV_MAX 4'hf
`endif

// file: include/dpcfg_pkg.sv
// Types shared by the datapath control word logic
package dpcfg_pkg;
  // Decoded interpolation factor, one-hot
  typedef enum logic [4:0] {
    RATE_1X = 5'h01,
    RATE_2X = 5'h02,
    RATE_4X = 5'h04,
    RATE_8X = 5'h08,
    RATE_16X = 5'h10
  } rate_e;
  // Settings handed to the data path
  typedef struct packed {
    logic dc_fix_ab;
    logic dc_fix_cd;
    logic gain_phase_ab;
    logic gain_phase_cd;
    logic [3:0] interp;
    logic fifo_on;
    logic fault_drive;
    logic fault_high;
    logic align_on;
    logic sinc_ab;
    logic sinc_cd;
  } dp_cfg_s;
  // Serial port state
  typedef enum logic [2:0] {
    SP_IDLE = 3'h1,
    SP_SHIFT = 3'h2,
    SP_DONE = 3'h4
  } sp_state_e;
endpackage

// file: logic/pin_sync.sv
// Three-stage synchroniser that reports a level once stages two and three agree
module pin_sync
  import dpcfg_pkg::*;
#(
  // Level the pin rests at; reset loads it so that no false edge follows release
  parameter logic RST_LEVEL = 1'b0
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic din,
  output logic dout
);
  logic [2:0] sync_q;  // Stage chain; bit 0 seen only by bit 1
  logic [2:0] sync_d;
  logic level_q;  // Accepted level
  logic level_d;

  // Next values: shift, accept when the two settled stages agree
  always_comb
  begin
    sync_d = {sync_q[1:0], din};
    level_d = (sync_q[1] == sync_q[2]) ? sync_q[2] : level_q;
  end

  // Registers only
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_q <= {3{RST_LEVEL}};
      level_q <= RST_LEVEL;
    end
    else
    begin
      sync_q <= sync_d;
      level_q <= level_d;
    end
  end

  assign dout = level_q;
endmodule

// file: sim/test_datapath_config_register.sv
// Self-checking bench for the datapath control word and its serial port
`include "dpcfg_map.svh"
module test_datapath_config_register
  import dpcfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // Pins driven by the bench
  logic ref_clk, resetn, sclk, sen_n, sdi, align_ev, fault_req;
  // Pins watched by the bench
  logic sdo, sdo_oe, fault_pin, fault_oe;
  dp_cfg_s cfg;
  rate_e rate;
  logic [4:0] div_en;
  // Tallies and scratch
  int bad_count, total_checks;
  logic [15:0] rd;
  logic oe;

  datapath_config_register u_datapath_config_register (
    .REF_CLK_IN(ref_clk), .RESETN_IN(resetn), .SCLK_IN(sclk), .SEN_N_IN(sen_n),
    .SDI_IN(sdi), .SDO_OUT(sdo), .SDO_OE_OUT(sdo_oe), .ALIGN_EVENT_IN(align_ev),
    .FAULT_REQ_IN(fault_req), .FAULT_OUT(fault_pin), .FAULT_OE_OUT(fault_oe),
    .CFG_OUT(cfg), .RATE_OUT(rate), .DIV_EN_OUT(div_en)
  );

  // 250 MHz reference clock
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Expected settings for a word; bits 6:5 have no output
  function automatic dp_cfg_s cfg_of(input logic [15:0] w);
    return {w[15:7], w[4:0]};
  endfunction

  // Compare with case inequality so unknowns never match
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Single place where the run ends
  task automatic print_verdict();
    if (bad_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // One 24-bit frame; phases are long because SCLK is resynchronised
  // A frame of fewer than 24 bits is cut short by raising SEN_N early
  task automatic sif(input logic rd_fl, input logic [6:0] adr, input logic [15:0] wd,
                     input int nbits = 24);
    logic [23:0] frame;
    frame = {rd_fl, adr, wd};
    rd = 16'h0000;
    oe = 1'b0;
    sen_n = 1'b0;
    for (int i = 23; i >= 24 - nbits; i--)
    begin
      sclk = 1'b0;
      sdi = frame[i];
      repeat (8) @(negedge ref_clk);
      // Read data has settled by the end of the low phase
      if (i < 16)
        rd[i] = sdo;
      if (i == 15)
        oe = sdo_oe;
      sclk = 1'b1;
      repeat (6) @(negedge ref_clk);
    end
    sclk = 1'b0;
    repeat (8) @(negedge ref_clk);
    sen_n = 1'b1;
    repeat (8) @(negedge ref_clk);
  endtask

  // Write the word, look at the settings, then read it back
  task automatic wr_chk(input logic [15:0] w);
    sif(1'b0, `DPCW_ADDR, w);
    check("cfg", {2'b00, cfg}, {2'b00, cfg_of(w)});
    sif(1'b1, `DPCW_ADDR, 16'h0000);
    check("readback", rd, w);
  endtask

  // Fire a sync event just after a divider wrap and see whether it realigns
  task automatic align_try(input logic en);
    int n;
    logic hit;
    wr_chk(en ? 16'h0004 : 16'h0000);
    n = 0;
    while (div_en !== 5'h1f && n < 20)
    begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 20)
    begin
      bad_count++;
      print_verdict();
    end
    align_ev = 1'b1;
    hit = 1'b0;
    // A free run reaches all-ones again only after 16 cycles
    for (int k = 0; k < 8 && !hit; k++)
    begin
      @(negedge ref_clk);
      hit = (div_en === 5'h1f);
    end
    check("align hit", {15'h0000, hit}, {15'h0000, en});
    if (hit)
    begin
      @(negedge ref_clk);
      check("div phase 1", {11'h000, div_en}, 16'h0001);
      @(negedge ref_clk);
      check("div phase 2", {11'h000, div_en}, 16'h0003);
    end
    align_ev = 1'b0;
    repeat (8) @(negedge ref_clk);
  endtask

  // Stimulus tables
  // Reserved bits 6:5 are always written as zero
  logic [15:0] pats [11] = '{16'h8000, 16'h4000, 16'h2000, 16'h1000, 16'h0080, 16'h0010,
                             16'h0008, 16'h0004, 16'h0002, 16'h0001, 16'h0400};
  logic [3:0] codes [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h3};
  rate_e rates [6] = '{RATE_1X, RATE_2X, RATE_4X, RATE_8X, RATE_16X, RATE_1X};
  logic [15:0] fwords [4] = '{16'h0018, 16'h0010, 16'h0000, 16'h0008};

  // Main sequence
  initial
  begin
    resetn = 1'b0;
    sclk = 1'b0;
    sen_n = 1'b1;
    sdi = 1'b0;
    align_ev = 1'b0;
    fault_req = 1'b0;
    bad_count = 0;
    total_checks = 0;
    repeat (10) @(negedge ref_clk);
    check("reset cfg", {2'b00, cfg}, {2'b00, cfg_of(`DPCW_RESET)});
    resetn = 1'b1;
    repeat (2) @(negedge ref_clk);
    sif(1'b1, `DPCW_ADDR, 16'h0000);
    check("reset word", rd, `DPCW_RESET);
    check("read drive", {15'h0000, oe}, 16'h0001);
    check("reset rate", {11'h000, rate}, {11'h000, RATE_8X});
    // Each field alone; reserved bits stay zero
    foreach (pats[k])
      wr_chk(pats[k]);
    // Every interpolation code, one undefined
    foreach (codes[k])
    begin
      wr_chk({4'h0, codes[k], 8'h00});
      check("rate", {11'h000, rate}, {11'h000, rates[k]});
    end
    // Fault pin drive and polarity against both request levels
    foreach (fwords[k])
    begin
      wr_chk(fwords[k]);
      for (int r = 0; r < 2; r++)
      begin
        fault_req = r[0];
        @(negedge ref_clk);
        check("fault oe", {15'h0000, fault_oe}, {15'h0000, fwords[k][4]});
        check("fault pin", {15'h0000, fault_pin},
              {15'h0000, fwords[k][3] ? r[0] : ~r[0]});
      end
    end
    // Another address must neither write nor drive read data
    sif(1'b0, 7'h01, 16'hffff);
    sif(1'b1, 7'h01, 16'h0000);
    check("other oe", {15'h0000, oe}, 16'h0000);
    sif(1'b1, `DPCW_ADDR, 16'h0000);
    check("word kept", rd, 16'h0008);
    // A write frame cut after 16 bits must be dropped
    sif(1'b0, `DPCW_ADDR, 16'hffff, 16);
    sif(1'b1, `DPCW_ADDR, 16'h0000);
    check("short frame", rd, 16'h0008);
    // Sync only with the enable bit set
    align_try(1'b1);
    align_try(1'b0);
    // Reset in mid-run restores the default word
    resetn = 1'b0;
    @(negedge ref_clk);
    check("rereset cfg", {2'b00, cfg}, {2'b00, cfg_of(`DPCW_RESET)});
    print_verdict();
  end
endmodule
